// ===== shared/cit_pkg.sv
package cit_pkg;
	localparam logic [5:0] OFS_FLAG = 6'h00;
	localparam logic [5:0] OFS_IEN  = 6'h04;
	localparam logic [5:0] OFS_ERRC = 6'h08;
	localparam logic [5:0] OFS_CFG1 = 6'h0C;
	localparam logic [5:0] OFS_CFG2 = 6'h10;
	localparam logic [5:0] OFS_FEN  = 6'h14;
	localparam logic [5:0] OFS_BP0  = 6'h18;
	localparam logic [5:0] OFS_BP3  = 6'h24;
	localparam logic [15:0] RST_ZERO = 16'h0000;
	localparam logic [15:0] RST_FEN  = 16'hFFFF;
	localparam logic [7:0]  IRQ_MASK  = 8'hEF;
	localparam logic [15:0] CFG1_MASK = 16'h00FF;
	localparam logic [15:0] CFG2_MASK = 16'h47FF;
	localparam int SJW_LSB  = 6;
	localparam int BRP_LSB  = 0;
	localparam int PH2_LSB  = 8;
	localparam int FREE_BIT = 7;
	localparam int SAM_BIT  = 6;
	localparam int PH1_LSB  = 3;
	localparam int PRS_LSB  = 0;
	localparam int WAKF_BIT = 14;
	localparam logic [3:0] IPT_TQ   = 4'h2;
	localparam logic [3:0] FIFO_SEL = 4'hF;
	localparam logic [8:0] TX_ERR_INC  = 9'h008;
	localparam logic [8:0] RX_MAJ_INC  = 9'h008;
	localparam logic [8:0] RX_MIN_INC  = 9'h001;
	localparam logic [8:0] CNT_MAX     = 9'h0FF;
	localparam logic [7:0] PASSIVE_LIM = 8'h7F;
	localparam logic [7:0] RX_REC_VAL  = 8'h77;
	localparam int CLK_NS       = 20;
	localparam int WAKE_FILT_NS = 200;
	localparam int WAKE_CYC     = (WAKE_FILT_NS + CLK_NS - 1) / CLK_NS;
endpackage : cit_pkg

// ===== design/cit_regs.sv
// Added by the designer: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module cit_regs
#(
	parameter int WAKE_CYCLES = cit_pkg::WAKE_CYC
)(
	input  wire logic        i_clk,
	input  wire logic        i_reset,
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [5:0]  i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic      [31:0] o_wb_dat,
	output logic             o_wb_ack,
	input  wire logic [7:0]  i_irq_event,
	output logic             o_irq,
	input  wire logic        i_tx_err,
	input  wire logic        i_tx_ok,
	input  wire logic        i_rx_err,
	input  wire logic        i_rx_err_major,
	input  wire logic        i_rx_ok,
	input  wire logic        i_bus_off_recover,
	output logic             o_tq_tick,
	output logic      [2:0]  o_sjw_tq,
	output logic      [3:0]  o_prop_tq,
	output logic      [3:0]  o_ph1_tq,
	output logic      [3:0]  o_ph2_tq,
	input  wire logic        i_can_rx,
	input  wire logic        i_sample_point,
	output logic             o_rx_bit,
	output logic             o_wake_dominant,
	input  wire logic        i_hit_valid,
	input  wire logic [3:0]  i_hit_filter,
	output logic             o_store_valid,
	output logic      [3:0]  o_store_target,
	output logic             o_store_fifo
);
	import cit_pkg::*;
	if (WAKE_CYCLES < 1 || WAKE_CYCLES > 255)
	begin : g_chk
		$error("WAKE_CYCLES must lie in 1..255");
	end

	function automatic logic [15:0] wmerge(
		input logic [15:0] old,
		input logic [31:0] dat,
		input logic [3:0]  sel,
		input logic [15:0] mask
	);
		logic [15:0] r;
		r = old;
		if (sel[0])
			r[7:0] = dat[7:0];
		if (sel[1])
			r[15:8] = dat[15:8];
		return r & mask;
	endfunction : wmerge

	function automatic logic [3:0] route_of(
		input logic [15:0] ptr,
		input logic [1:0]  slot
	);
		return ptr[{slot, 2'b00} +: 4];
	endfunction : route_of

	// Bus slave
	logic        ack_reg, ack_next;
	logic [15:0] rdat_reg, rdat_next;
	logic        req, wr_go, rd_go;

	// Registers
	logic [7:0]  flag_reg, flag_next;
	logic [15:0] ien_reg, ien_next;
	logic [15:0] cfg1_reg, cfg1_next;
	logic [15:0] cfg2_reg, cfg2_next;
	logic [15:0] fen_reg, fen_next;
	logic [15:0] bp_reg [4], bp_next [4];
	logic [7:0]  tec_reg, tec_next;
	logic [7:0]  rec_reg, rec_next;
	logic [8:0]  sum;

	assign req   = i_wb_cyc & i_wb_stb;
	assign wr_go = req & i_wb_we & ack_reg;
	assign rd_go = req & ~i_wb_we & ack_reg;

	always_comb
	begin
		ack_next  = req & ~ack_reg;
		rdat_next = rdat_reg;
		if (ack_next && !i_wb_we)
		begin
			case (i_wb_adr)
				OFS_FLAG: rdat_next = {8'h00, flag_reg};
				OFS_IEN:  rdat_next = ien_reg;
				OFS_ERRC: rdat_next = {tec_reg, rec_reg};
				OFS_CFG1: rdat_next = cfg1_reg;
				OFS_CFG2: rdat_next = cfg2_reg;
				OFS_FEN:  rdat_next = fen_reg;
				6'h18:    rdat_next = bp_reg[0];
				6'h1C:    rdat_next = bp_reg[1];
				6'h20:    rdat_next = bp_reg[2];
				OFS_BP3:  rdat_next = bp_reg[3];
				default:  rdat_next = RST_ZERO;
			endcase
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			ack_reg  <= 1'b0;
			rdat_reg <= RST_ZERO;
		end
		else
		begin
			ack_reg  <= ack_next;
			rdat_reg <= rdat_next;
		end
	end

	assign o_wb_ack = ack_reg;
	assign o_wb_dat = {16'h0000, rdat_reg};

	// Events are OR'd in last so a flag raised in a clearing cycle survives
	always_comb
	begin
		flag_next = flag_reg;
		if (wr_go && i_wb_adr == OFS_FLAG && i_wb_sel[0])
			flag_next = flag_reg & i_wb_dat[7:0];
		if (rd_go && i_wb_adr == OFS_FLAG)
			flag_next = 8'h00;
		flag_next = flag_next | (i_irq_event & IRQ_MASK);
	end

	always_comb
	begin
		ien_next  = ien_reg;
		cfg1_next = cfg1_reg;
		cfg2_next = cfg2_reg;
		fen_next  = fen_reg;
		for (int k = 0; k < 4; k++)
			bp_next[k] = bp_reg[k];
		if (wr_go)
		begin
			case (i_wb_adr)
				OFS_IEN:  ien_next  = wmerge(ien_reg, i_wb_dat, i_wb_sel,
					{8'h00, IRQ_MASK});
				OFS_CFG1: cfg1_next = wmerge(cfg1_reg, i_wb_dat, i_wb_sel, CFG1_MASK);
				OFS_CFG2: cfg2_next = wmerge(cfg2_reg, i_wb_dat, i_wb_sel, CFG2_MASK);
				OFS_FEN:  fen_next  = wmerge(fen_reg, i_wb_dat, i_wb_sel, RST_FEN);
				6'h18:    bp_next[0] = wmerge(bp_reg[0], i_wb_dat, i_wb_sel, RST_FEN);
				6'h1C:    bp_next[1] = wmerge(bp_reg[1], i_wb_dat, i_wb_sel, RST_FEN);
				6'h20:    bp_next[2] = wmerge(bp_reg[2], i_wb_dat, i_wb_sel, RST_FEN);
				OFS_BP3:  bp_next[3] = wmerge(bp_reg[3], i_wb_dat, i_wb_sel, RST_FEN);
				default:  ;
			endcase
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			flag_reg <= 8'h00;
			ien_reg  <= RST_ZERO;
			cfg1_reg <= RST_ZERO;
			cfg2_reg <= RST_ZERO;
			fen_reg  <= RST_FEN;
			for (int k = 0; k < 4; k++)
				bp_reg[k] <= RST_ZERO;
		end
		else
		begin
			flag_reg <= flag_next;
			ien_reg  <= ien_next;
			cfg1_reg <= cfg1_next;
			cfg2_reg <= cfg2_next;
			fen_reg  <= fen_next;
			for (int k = 0; k < 4; k++)
				bp_reg[k] <= bp_next[k];
		end
	end

	assign o_irq = |(flag_reg & ien_reg[7:0]);
	// Error counts saturate at the field limit; bus-off is kept by the engine
	always_comb
	begin
		tec_next = tec_reg;
		rec_next = rec_reg;
		sum      = 9'h000;
		if (i_bus_off_recover)
		begin
			tec_next = 8'h00;
			rec_next = 8'h00;
		end
		else
		begin
			if (i_tx_err)
			begin
				sum      = {1'b0, tec_reg} + TX_ERR_INC;
				tec_next = (sum > CNT_MAX) ? 8'hFF : sum[7:0];
			end
			else if (i_tx_ok && tec_reg != 8'h00)
				tec_next = tec_reg - 8'h01;
			if (i_rx_err)
			begin
				sum = {1'b0, rec_reg} + (i_rx_err_major ? RX_MAJ_INC : RX_MIN_INC);
				rec_next = (sum > CNT_MAX) ? 8'hFF : sum[7:0];
			end
			else if (i_rx_ok)
			begin
				if (rec_reg > PASSIVE_LIM)
					rec_next = RX_REC_VAL;
				else if (rec_reg != 8'h00)
					rec_next = rec_reg - 8'h01;
			end
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			tec_reg <= 8'h00;
			rec_reg <= 8'h00;
		end
		else
		begin
			tec_reg <= tec_next;
			rec_reg <= rec_next;
		end
	end

	// Bit timing
	logic [6:0] div_reg, div_next, div_last;
	logic       tick_reg, tick_next;
	logic [2:0] sjw_next;
	logic [3:0] prop_next, ph1_next, ph2_next;
	// Divider period is 2*(setting+1); a shrunk setting wraps at once instead of overflowing
	assign div_last = {cfg1_reg[BRP_LSB +: 6], 1'b1};

	always_comb
	begin
		tick_next = (div_reg >= div_last);
		div_next  = tick_next ? 7'h00 : div_reg + 7'h01;
		sjw_next  = {1'b0, cfg1_reg[SJW_LSB +: 2]} + 3'h1;
		prop_next = {1'b0, cfg2_reg[PRS_LSB +: 3]} + 4'h1;
		ph1_next  = {1'b0, cfg2_reg[PH1_LSB +: 3]} + 4'h1;
		if (cfg2_reg[FREE_BIT])
			ph2_next = {1'b0, cfg2_reg[PH2_LSB +: 3]} + 4'h1;
		else
			ph2_next = (ph1_next > IPT_TQ) ? ph1_next : IPT_TQ;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			div_reg   <= 7'h00;
			tick_reg  <= 1'b0;
			o_sjw_tq  <= 3'h1;
			o_prop_tq <= 4'h1;
			o_ph1_tq  <= 4'h1;
			o_ph2_tq  <= IPT_TQ;
		end
		else
		begin
			div_reg   <= div_next;
			tick_reg  <= tick_next;
			o_sjw_tq  <= sjw_next;
			o_prop_tq <= prop_next;
			o_ph1_tq  <= ph1_next;
			o_ph2_tq  <= ph2_next;
		end
	end

	assign o_tq_tick = tick_reg;

	// Bus sampling and wake filter
	logic [2:0] hist_reg, hist_next;
	logic [7:0] wcnt_reg, wcnt_next;
	logic       rxb_reg, rxb_next, wake_reg, wake_next, maj;
	always_comb
	begin
		hist_next = tick_reg ? {hist_reg[1:0], i_can_rx} : hist_reg;
		maj       = (hist_reg[0] & (hist_reg[1] | hist_reg[2])) | (hist_reg[1] & hist_reg[2]);
		rxb_next  = rxb_reg;
		if (i_sample_point)
			rxb_next = cfg2_reg[SAM_BIT] ? maj : hist_reg[0];
		// Short dominant glitches never reach the wake logic when filtered
		wcnt_next = wcnt_reg;
		if (i_can_rx)
			wcnt_next = 8'h00;
		else if (wcnt_reg != WAKE_CYCLES[7:0])
			wcnt_next = wcnt_reg + 8'h01;
		wake_next = cfg2_reg[WAKF_BIT] ? (wcnt_next == WAKE_CYCLES[7:0]) : ~i_can_rx;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			hist_reg <= 3'h7;
			rxb_reg  <= 1'b1;
			wcnt_reg <= 8'h00;
			wake_reg <= 1'b0;
		end
		else
		begin
			hist_reg <= hist_next;
			rxb_reg  <= rxb_next;
			wcnt_reg <= wcnt_next;
			wake_reg <= wake_next;
		end
	end

	assign o_rx_bit        = rxb_reg;
	assign o_wake_dominant = wake_reg;

	// Acceptance routing
	logic       stv_reg, stv_next;
	logic [3:0] tgt_reg, tgt_next;
	always_comb
	begin
		stv_next = i_hit_valid & fen_reg[i_hit_filter];
		tgt_next = tgt_reg;
		if (stv_next)
			tgt_next = route_of(bp_reg[i_hit_filter[3:2]], i_hit_filter[1:0]);
	end

	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			stv_reg <= 1'b0;
			tgt_reg <= 4'h0;
		end
		else
		begin
			stv_reg <= stv_next;
			tgt_reg <= tgt_next;
		end
	end

	assign o_store_valid  = stv_reg;
	assign o_store_target = tgt_reg;
	assign o_store_fifo   = (tgt_reg == FIFO_SEL);
endmodule : cit_regs

// ===== test/cit_can_node.sv
`timescale 1ns/1ps
module cit_can_node #(
	parameter int BIT_CYC = 40
)(
	input  logic       i_clk,
	input  logic       i_go,
	input  logic [7:0] i_bits,
	output logic       o_rx,
	output logic       o_sp
);
	// Idle bus reads recessive, as the bus pull level does with no driver
	initial
	begin
		o_rx = 1'h1;
		o_sp = 1'h0;
		forever
		begin
			@(posedge i_clk);
			if (i_go)
			begin
				for (int b = 7; b >= 0; b--)
				begin
					o_rx <= i_bits[b];
					repeat (BIT_CYC / 2) @(posedge i_clk);
					o_sp <= 1'h1;
					@(posedge i_clk);
					o_sp <= 1'h0;
					repeat (BIT_CYC / 2 - 1) @(posedge i_clk);
				end
				o_rx <= 1'h1;
			end
		end
	end
endmodule : cit_can_node

// ===== test/cit_regs_checker.sv
`timescale 1ns/1ps
module cit_regs_checker
	import cit_pkg::*;
(
	input logic        i_clk,
	input logic        i_reset,
	input logic        i_wb_cyc,
	input logic        i_wb_stb,
	input logic        i_wb_we,
	input logic [5:0]  i_wb_adr,
	input logic [3:0]  i_wb_sel,
	input logic [31:0] i_wb_dat,
	input logic        o_wb_ack,
	input logic        i_hit_valid,
	input logic [3:0]  i_hit_filter,
	input logic        o_tq_tick,
	input logic [2:0]  o_sjw_tq,
	input logic [3:0]  o_prop_tq,
	input logic [3:0]  o_ph1_tq,
	input logic [3:0]  o_ph2_tq,
	input logic        o_store_valid,
	input logic [3:0]  o_store_target,
	input logic        o_store_fifo
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);
	logic       wr, wr2;
	logic [1:0] sjw_w;
	logic [3:0] ph1_n, prs_n, ph2_n;
	assign wr = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack && i_wb_sel[1:0] == 2'h3;
	assign wr2 = wr && i_wb_adr == OFS_CFG2;
	assign ph1_n = {1'h0, i_wb_dat[5:3]} + 4'h1;
	assign prs_n = {1'h0, i_wb_dat[2:0]} + 4'h1;
	assign ph2_n = {1'h0, i_wb_dat[10:8]} + 4'h1;
	// Jump width reaches its output two cycles after the write, with no divider wait, so its value is kept here
	always_ff @(posedge i_clk)
		if (wr && i_wb_adr == OFS_CFG1)
			sjw_w <= i_wb_dat[7:6];
	// Shadow of the route pointers, fed only by accepted bus writes that enable both low byte lanes
	logic [15:0] bp_sh [4];
	logic [3:0]  exp_tgt;
	always_ff @(posedge i_clk)
		if (i_reset)
			bp_sh <= '{default: 16'h0000};
		else if (wr && i_wb_adr >= OFS_BP0 && i_wb_adr <= OFS_BP3 && i_wb_adr[1:0] == 2'h0)
			bp_sh[2'(i_wb_adr[5:2] - 4'h6)] <= i_wb_dat[15:0];
	assign exp_tgt = bp_sh[i_hit_filter[3:2]][{i_hit_filter[1:0], 2'h0} +: 4];
	ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack too long");
	ack_answer_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
		else $error("no ack");
	sjw_len_a: assert property (
		wr && i_wb_adr == OFS_CFG1 |-> ##[2:150] o_sjw_tq == {1'h0, sjw_w} + 3'h1)
		else $error("jump width");
	seg_len_a: assert property (
		wr2 |-> ##2 o_ph1_tq == $past(ph1_n, 2) && o_prop_tq == $past(prs_n, 2))
		else $error("segment length");
	ph2_free_a: assert property (
		wr2 && i_wb_dat[7] |-> ##2 o_ph2_tq == $past(ph2_n, 2))
		else $error("phase2 free");
	ph2_auto_a: assert property (
		wr2 && !i_wb_dat[7] |-> ##2 o_ph2_tq == (o_ph1_tq > IPT_TQ ? o_ph1_tq : IPT_TQ))
		else $error("phase2 auto");
	tick_gap_a: assert property (o_tq_tick |=> !o_tq_tick)
		else $error("quantum tick");
	store_hit_a: assert property (o_store_valid |-> $past(i_hit_valid))
		else $error("store without hit");
	store_fifo_a: assert property (
		o_store_valid |-> o_store_target == $past(exp_tgt)
			&& o_store_fifo == ($past(exp_tgt) == FIFO_SEL))
		else $error("store target");
	cover property (o_store_valid && o_store_fifo);
	cover property (wr2 && !i_wb_dat[7]);
	cover property (o_tq_tick ##6 o_tq_tick);
endmodule : cit_regs_checker

bind cit_regs cit_regs_checker i_cit_regs_checker (.i_clk, .i_reset, .i_wb_cyc, .i_wb_stb,
	.i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_ack, .i_hit_valid, .i_hit_filter, .o_tq_tick,
	.o_sjw_tq, .o_prop_tq, .o_ph1_tq, .o_ph2_tq, .o_store_valid, .o_store_target,
	.o_store_fifo);

// ===== test/tb_cit_regs.sv
`timescale 1ns/1ps
module tb_cit_regs;
	import cit_pkg::*;
	logic        i_clk = 1'h0, i_reset = 1'h1;
	logic        cyc = 1'h0, stb = 1'h0, we = 1'h0, send = 1'h0;
	logic [5:0]  adr = 6'h00;
	logic [31:0] wdat = 32'h0000_0000;
	logic [14:0] st = 15'h0000;
	logic [3:0]  hf = 4'h0;
	logic [7:0]  bits = 8'hB2;
	logic [31:0] rdat;
	logic        ack, irq, tick, rxb, wake, sv, sfifo, can_rx, sp;
	logic [2:0]  resync_jump_width;
	logic [3:0]  prop, ph1, ph2, tgt;
	int          miscompares = 0, n_compared = 0;

	always #10 i_clk = ~i_clk;

	cit_regs #(.WAKE_CYCLES(3)) i_cit_regs (.i_clk, .i_reset, .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'h3), .i_wb_dat(wdat), .o_wb_dat(rdat),
		.o_wb_ack(ack), .i_irq_event(st[7:0]), .o_irq(irq), .i_tx_err(st[8]),
		.i_tx_ok(st[9]), .i_rx_err(st[10]), .i_rx_err_major(st[11]), .i_rx_ok(st[12]),
		.i_bus_off_recover(st[13]), .o_tq_tick(tick), .o_sjw_tq(resync_jump_width), .o_prop_tq(prop),
		.o_ph1_tq(ph1), .o_ph2_tq(ph2), .i_can_rx(can_rx), .i_sample_point(sp),
		.o_rx_bit(rxb), .o_wake_dominant(wake), .i_hit_valid(st[14]), .i_hit_filter(hf),
		.o_store_valid(sv), .o_store_target(tgt), .o_store_fifo(sfifo));
	cit_can_node i_cit_can_node (.i_clk, .i_go(send), .i_bits(bits), .o_rx(can_rx), .o_sp(sp));

	task automatic end_of_test;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		n_compared++;
		if (s !== e)
		begin
			miscompares++;
			$display("mismatch at %0t: saw %h expected %h", $time, s, e);
		end
	endtask : chk

	// Bounded wait on ack, tick, sample point or idle bus
	task automatic wait_hi(input int s, output int n);
		n = 0;
		do
		begin
			@(posedge i_clk);
			n++;
		end
		while ((s == 0 ? ack : s == 1 ? tick : s == 2 ? sp : can_rx) !== 1'h1 && n < 300);
		if (n >= 300)
		begin
			miscompares++;
			end_of_test;
		end
	endtask : wait_hi

	task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] d,
		output logic [15:0] q);
		int n;
		@(posedge i_clk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= {16'h0000, d};
		wait_hi(0, n);
		q = rdat[15:0];
		cyc <= 1'h0;
		stb <= 1'h0;
		#1;
	endtask : bus

	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		logic [15:0] q;
		bus(1'h1, a, d, q);
	endtask : wr

	task automatic rd(input logic [5:0] a, input logic [15:0] e);
		logic [15:0] q;
		bus(1'h0, a, 16'h0000, q);
		chk(q, e);
	endtask : rd

	task automatic go(input logic [14:0] v);
		@(posedge i_clk);
		st <= v;
		@(posedge i_clk);
		st <= 15'h0000;
		#1;
	endtask : go

	initial
	begin
		logic [15:0] msk [11];
		logic [15:0] cf [3];
		logic [11:0] ex [3];
		logic [15:0] v;
		int n;
		msk = '{16'h0000, 16'h00EF, 16'h0000, 16'h00FF, 16'h47FF, 16'hFFFF,
			16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0000};
		cf = '{16'h05BA, 16'h0707, 16'h0020};
		ex = '{12'h683, 12'h218, 12'h551};
		repeat (16) @(posedge i_clk);
		i_reset <= 1'h0;
		for (int i = 0; i < 11; i++)
			rd(6'(4 * i), i == 5 ? RST_FEN : RST_ZERO);
		$display("reset values done");
		for (int i = 0; i < 11; i++)
		begin
			wr(6'(4 * i), 16'hFFFF);
			rd(6'(4 * i), msk[i]);
		end
		$display("access test done");
		for (int b = 0; b < 8; b++)
			if (b != 4)
			begin
				wr(OFS_IEN, 16'h0000);
				go(15'(1 << b));
				chk(irq, 16'h0000);
				wr(OFS_IEN, 16'(1 << b));
				chk(irq, 16'h0001);
				wr(OFS_FLAG, 16'(1 << b));
				chk(irq, 16'h0001);
				wr(OFS_FLAG, 16'h0000);
				chk(irq, 16'h0000);
			end
		go(15'h0013);
		rd(OFS_FLAG, 16'h0003);
		rd(OFS_FLAG, 16'h0000);
		$display("interrupt test done");
		go(15'h0100);
		go(15'h0100);
		go(15'h0200);
		go(15'h0400);
		go(15'h0C00);
		go(15'h1000);
		wr(OFS_ERRC, 16'hFFFF);
		rd(OFS_ERRC, 16'h0F08);
		go(15'h2000);
		rd(OFS_ERRC, 16'h0000);
		$display("counter test done");
		for (int k = 0; k < 4; k++)
		begin
			for (int j = 0; j < 4; j++)
				v[4 * j +: 4] = 4'(15 - 4 * k - j);
			wr(6'(OFS_BP0 + 4 * k), v);
		end
		wr(OFS_FEN, 16'hFFDF);
		for (int f = 0; f < 16; f++)
		begin
			hf <= 4'(f);
			go(15'h4000);
			chk(sv, 16'(f != 5));
			if (f != 5)
				chk(tgt, 16'(15 - f));
			chk(sfifo, 16'(f == 0));
		end
		$display("routing test done");
		wr(OFS_CFG1, 16'h00C2);
		repeat (3) wait_hi(1, n);
		chk(16'(n), 16'h0006);
		chk(resync_jump_width, 16'h0004);
		for (int i = 0; i < 3; i++)
		begin
			wr(OFS_CFG2, cf[i]);
			repeat (3) @(posedge i_clk);
			#1;
			chk({ph2, ph1, prop}, ex[i]);
		end
		$display("timing test done");
		for (int m = 0; m < 4; m++)
		begin
			v = 16'h0080;
			v[6] = m[0];
			v[14] = m[1];
			wr(OFS_CFG2, v);
			@(posedge i_clk);
			send <= 1'h1;
			@(posedge i_clk);
			send <= 1'h0;
			for (int b = 7; b >= 0; b--)
			begin
				wait_hi(2, n);
				repeat (2) @(posedge i_clk);
				#1;
				chk(rxb, 16'(bits[b]));
				chk(wake, 16'(!bits[b]));
			end
			wait_hi(3, n);
		end
		$display("sampling test done");
		end_of_test;
	end
endmodule : tb_cit_regs
